// *** rtl/pls_pkg.sv ***
// package: constants, types and encodings of the partition label register bank
package pls_pkg;

  // ***************************************************************
  // register layout
  // ***************************************************************
  localparam int PLS_REG_W = 64;
  localparam int PLS_EN_BIT = 63;
  localparam int PLS_TRAP_LOWER_BIT = 62;
  localparam int PLS_TRAP_USER_BIT = 49;
  localparam int PLS_TRAP_KERNEL_BIT = 48;
  localparam int PLS_FIELDS_W = 48;
  localparam int PLS_HYP_RSVD_HI = 62;
  localparam int PLS_HYP_RSVD_LO = 50;
  localparam int PLS_MON_RSVD_HI = 61;
  localparam int PLS_MON_RSVD_LO = 48;

  // ***************************************************************
  // exception levels and default labels
  // ***************************************************************
  localparam logic [1:0] PLS_EL0 = 2'h0;
  localparam logic [1:0] PLS_EL1 = 2'h1;
  localparam logic [1:0] PLS_EL2 = 2'h2;
  localparam logic [1:0] PLS_EL3 = 2'h3;
  localparam logic [15:0] PLS_DEF_PARTID = 16'h0000;
  localparam logic [7:0] PLS_DEF_PMG = 8'h00;
  localparam logic [PLS_REG_W-1:0] PLS_ZERO = 64'h0000_0000_0000_0000;

  // ***************************************************************
  // types
  // ***************************************************************
  typedef enum logic [2:0] {
    PLS_SREG_USER,
    PLS_SREG_KERNEL,
    PLS_SREG_HYP,
    PLS_SREG_MONITOR,
    PLS_SREG_OTHER
  } pls_sreg_e;

  typedef enum logic [1:0] {
    PLS_RESP_OK,
    PLS_RESP_TRAP_EL2,
    PLS_RESP_TRAP_EL3,
    PLS_RESP_UNDEF
  } pls_resp_e;

  typedef struct packed {
    logic [7:0] data_monitor_group;
    logic [7:0] instr_monitor_group;
    logic [15:0] data_partition_id;
    logic [15:0] instr_partition_id;
  } pls_fields_s;

  typedef struct packed {
    logic [15:0] partition_id;
    logic [7:0] monitor_group;
  } pls_label_s;

  typedef struct packed {
    logic valid;
    logic write;
    pls_sreg_e sreg;
    logic [1:0] el;
    logic [PLS_REG_W-1:0] wdata;
  } pls_req_s;

  typedef struct packed {
    logic nonsecure_state;
    logic secure_hyp_enable;
    logic el2_aarch64;
    logic nested_virt_enable;
    logic nested_virt_redirect;
  } pls_ctx_s;

endpackage : pls_pkg

// *** rtl/pls_label_fields.sv ***
// module: label field store (groups and partition ids), no reset by design
module pls_label_fields (
  input wire logic core_clk,
  input wire logic clk_en,
  input wire logic wr_en,
  input wire pls_pkg::pls_fields_s wdata,
  output pls_pkg::pls_fields_s fields_q
);
  import pls_pkg::*;

  pls_fields_s fields_d;

  // next value: load on a taken write
  always_comb begin
    fields_d = fields_q;
    if (wr_en) begin
      fields_d = wdata;
    end
  end

  // fields are unknown after reset, so no reset term
  always_ff @(posedge core_clk) begin
    if (clk_en) begin
      fields_q <= fields_d;
    end
  end

endmodule : pls_label_fields

// *** rtl/pls_trap_decode.sv ***
// module: decodes undefined, el3 and el2 trap outcomes of one register access
module pls_trap_decode #(
  parameter bit HAS_PART = 1'b1,
  parameter bit HAS_EL2 = 1'b1,
  parameter bit HAS_EL3 = 1'b1
) (
  input pls_pkg::pls_req_s req,
  input pls_pkg::pls_ctx_s ctx,
  input wire logic trap_lower,
  input wire logic trap_user,
  input wire logic trap_kernel,
  input wire logic el2_enabled,
  output pls_pkg::pls_resp_e resp
);
  import pls_pkg::*;

  logic full_nested;

  assign full_nested = ctx.nested_virt_enable && ctx.nested_virt_redirect;

  // undefined first, then monitor trap, then hypervisor trap
  always_comb begin
    resp = PLS_RESP_OK;
    unique case (req.sreg)
      PLS_SREG_USER, PLS_SREG_KERNEL, PLS_SREG_OTHER: begin
        if (req.el == PLS_EL0) begin
          resp = PLS_RESP_UNDEF;
        end
      end
      PLS_SREG_HYP: begin
        if (!HAS_PART || !HAS_EL2 || req.el < PLS_EL2) begin
          resp = PLS_RESP_UNDEF;
        end
      end
      PLS_SREG_MONITOR: begin
        if (!HAS_PART || !HAS_EL3 || req.el != PLS_EL3) begin
          resp = PLS_RESP_UNDEF;
        end
      end
    endcase
    if (resp == PLS_RESP_OK && trap_lower && req.el != PLS_EL3) begin
      if (req.el == PLS_EL2) begin
        resp = PLS_RESP_TRAP_EL3;
      end else if (!full_nested) begin
        resp = PLS_RESP_TRAP_EL3;
      end
    end
    if (resp == PLS_RESP_OK && !trap_lower && req.el == PLS_EL1 && el2_enabled
        && ctx.el2_aarch64) begin
      if (req.sreg == PLS_SREG_KERNEL && ((trap_kernel && !ctx.nested_virt_enable)
          || (ctx.nested_virt_enable && !ctx.nested_virt_redirect))) begin
        resp = PLS_RESP_TRAP_EL2;
      end
      if (req.sreg == PLS_SREG_USER && trap_user) begin
        resp = PLS_RESP_TRAP_EL2;
      end
    end
  end

endmodule : pls_trap_decode

// *** rtl/pls_label_regs.sv ***
// module: partition label register bank with access traps and request labelling
module pls_label_regs #(
  parameter bit HAS_PART = 1'b1,
  parameter bit HAS_EL2 = 1'b1,
  parameter bit HAS_EL3 = 1'b1
) (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic clk_en,
  input wire logic warm_reset,
  input wire logic reset_el_aarch64,
  input pls_pkg::pls_req_s req,
  input pls_pkg::pls_ctx_s ctx,
  input wire logic [1:0] cur_el,
  input pls_pkg::pls_label_s lower_data_label,
  input pls_pkg::pls_label_s lower_instr_label,
  output logic resp_valid,
  output pls_pkg::pls_resp_e resp_code,
  output logic [pls_pkg::PLS_REG_W-1:0] rdata,
  output logic label_enable,
  output pls_pkg::pls_label_s data_label,
  output pls_pkg::pls_label_s instr_label
);
  import pls_pkg::*;

  // ***************************************************************
  // declarations
  // ***************************************************************
  logic en_q;
  logic en_d;
  logic trap_lower_q;
  logic trap_lower_d;
  logic trap_user_q;
  logic trap_user_d;
  logic trap_kernel_q;
  logic trap_kernel_d;
  logic el2_enabled;
  logic wr_ok;
  logic hyp_wr;
  logic mon_wr;
  logic kernel_wr;
  logic warm_apply;
  pls_resp_e resp_now;
  pls_fields_s hyp_fields_q;
  pls_fields_s mon_fields_q;
  logic resp_valid_q;
  logic resp_valid_d;
  pls_resp_e resp_code_q;
  pls_resp_e resp_code_d;
  logic [PLS_REG_W-1:0] rdata_q;
  logic [PLS_REG_W-1:0] rdata_d;
  pls_label_s data_label_q;
  pls_label_s data_label_d;
  pls_label_s instr_label_q;
  pls_label_s instr_label_d;

  // ***************************************************************
  // access decode
  // ***************************************************************

  // hypervisor level only counts when present and on in this state
  assign el2_enabled = HAS_EL2 && (ctx.nonsecure_state || ctx.secure_hyp_enable);

  pls_trap_decode #(
    .HAS_PART(HAS_PART),
    .HAS_EL2(HAS_EL2),
    .HAS_EL3(HAS_EL3)
  ) u_trap (
    .req(req),
    .ctx(ctx),
    .trap_lower(trap_lower_q),
    .trap_user(trap_user_q),
    .trap_kernel(trap_kernel_q),
    .el2_enabled(el2_enabled),
    .resp(resp_now)
  );

  // write strobes, only for accesses that neither trap nor fault
  assign wr_ok = req.valid && req.write && resp_now == PLS_RESP_OK;
  assign hyp_wr = wr_ok && req.sreg == PLS_SREG_HYP;
  assign mon_wr = wr_ok && req.sreg == PLS_SREG_MONITOR;
  assign kernel_wr = wr_ok && req.sreg == PLS_SREG_KERNEL;
  assign warm_apply = warm_reset && reset_el_aarch64;

  // ***************************************************************
  // control bits
  // ***************************************************************

  // next values of enable and trap bits; reserved bits never stored
  always_comb begin
    en_d = en_q;
    trap_lower_d = trap_lower_q;
    trap_user_d = trap_user_q;
    trap_kernel_d = trap_kernel_q;
    if (mon_wr) begin
      en_d = req.wdata[PLS_EN_BIT];
      trap_lower_d = req.wdata[PLS_TRAP_LOWER_BIT];
    end
    if (hyp_wr) begin
      if (!HAS_EL3) begin
        en_d = req.wdata[PLS_EN_BIT];
      end
      trap_user_d = req.wdata[PLS_TRAP_USER_BIT];
      trap_kernel_d = req.wdata[PLS_TRAP_KERNEL_BIT];
    end
    if (kernel_wr && !HAS_EL3 && !HAS_EL2) begin
      en_d = req.wdata[PLS_EN_BIT];
    end
    if (warm_apply) begin
      en_d = 1'b0;
      if (!HAS_EL3) begin
        trap_user_d = 1'b1;
        trap_kernel_d = 1'b1;
      end
    end
  end

  // one enable flop serves the kernel, hyp and monitor views; cold reset sets all three trap bits
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      en_q <= 1'b0;
      trap_lower_q <= 1'b1;
      trap_user_q <= 1'b1;
      trap_kernel_q <= 1'b1;
    end else if (clk_en) begin
      en_q <= en_d;
      trap_lower_q <= trap_lower_d;
      trap_user_q <= trap_user_d;
      trap_kernel_q <= trap_kernel_d;
    end
  end

  // ***************************************************************
  // label field stores
  // ***************************************************************

  pls_label_fields u_hyp_fields (
    .core_clk(core_clk),
    .clk_en(clk_en),
    .wr_en(hyp_wr),
    .wdata(pls_fields_s'(req.wdata[PLS_FIELDS_W-1:0])),
    .fields_q(hyp_fields_q)
  );

  pls_label_fields u_mon_fields (
    .core_clk(core_clk),
    .clk_en(clk_en),
    .wr_en(mon_wr),
    .wdata(pls_fields_s'(req.wdata[PLS_FIELDS_W-1:0])),
    .fields_q(mon_fields_q)
  );

  // ***************************************************************
  // access response and read data
  // ***************************************************************

  // read view of the addressed register, reserved bits as zero
  always_comb begin
    resp_valid_d = req.valid;
    resp_code_d = resp_now;
    rdata_d = PLS_ZERO;
    if (req.valid && !req.write && resp_now == PLS_RESP_OK) begin
      unique case (req.sreg)
        PLS_SREG_HYP: begin
          rdata_d[PLS_EN_BIT] = en_q;
          rdata_d[PLS_TRAP_USER_BIT] = trap_user_q;
          rdata_d[PLS_TRAP_KERNEL_BIT] = trap_kernel_q;
          rdata_d[PLS_FIELDS_W-1:0] = hyp_fields_q;
        end
        PLS_SREG_MONITOR: begin
          rdata_d[PLS_EN_BIT] = en_q;
          rdata_d[PLS_TRAP_LOWER_BIT] = trap_lower_q;
          rdata_d[PLS_FIELDS_W-1:0] = mon_fields_q;
        end
        PLS_SREG_KERNEL: begin
          rdata_d[PLS_EN_BIT] = en_q;
        end
        PLS_SREG_USER, PLS_SREG_OTHER: begin
          rdata_d = PLS_ZERO;
        end
      endcase
    end
  end

  // response registers
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      resp_valid_q <= 1'b0;
      resp_code_q <= PLS_RESP_OK;
      rdata_q <= PLS_ZERO;
    end else if (clk_en) begin
      resp_valid_q <= resp_valid_d;
      resp_code_q <= resp_code_d;
      rdata_q <= rdata_d;
    end else begin
      resp_valid_q <= 1'b0;
      resp_code_q <= resp_code_q;
      rdata_q <= rdata_q;
    end
  end

  // ***************************************************************
  // request labelling
  // ***************************************************************

  // pick label source from level and enable
  always_comb begin
    data_label_d = '{partition_id: PLS_DEF_PARTID, monitor_group: PLS_DEF_PMG};
    instr_label_d = '{partition_id: PLS_DEF_PARTID, monitor_group: PLS_DEF_PMG};
    if (en_q) begin
      unique case (cur_el)
        PLS_EL3: begin
          data_label_d = '{partition_id: mon_fields_q.data_partition_id,
                           monitor_group: mon_fields_q.data_monitor_group};
          instr_label_d = '{partition_id: mon_fields_q.instr_partition_id,
                            monitor_group: mon_fields_q.instr_monitor_group};
        end
        PLS_EL2: begin
          if (el2_enabled) begin
            data_label_d = '{partition_id: hyp_fields_q.data_partition_id,
                             monitor_group: hyp_fields_q.data_monitor_group};
            instr_label_d = '{partition_id: hyp_fields_q.instr_partition_id,
                              monitor_group: hyp_fields_q.instr_monitor_group};
          end
        end
        PLS_EL1, PLS_EL0: begin
          data_label_d = lower_data_label;
          instr_label_d = lower_instr_label;
        end
      endcase
    end
  end

  // label registers
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      data_label_q <= '{partition_id: PLS_DEF_PARTID, monitor_group: PLS_DEF_PMG};
      instr_label_q <= '{partition_id: PLS_DEF_PARTID, monitor_group: PLS_DEF_PMG};
    end else if (clk_en) begin
      data_label_q <= data_label_d;
      instr_label_q <= instr_label_d;
    end
  end

  // outputs
  assign resp_valid = resp_valid_q;
  assign resp_code = resp_code_q;
  assign rdata = rdata_q;
  assign label_enable = en_q;
  assign data_label = data_label_q;
  assign instr_label = instr_label_q;

  // ***************************************************************
  // assertions
  // ***************************************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);

  hyp_trap_mon_a: assert property (
    clk_en && req.valid && req.el == PLS_EL2 && req.sreg == PLS_SREG_HYP && trap_lower_q
    |=> resp_valid && resp_code == (HAS_PART && HAS_EL2 ? PLS_RESP_TRAP_EL3 : PLS_RESP_UNDEF))
    else $error("hyp level access not trapped to monitor");

  kernel_trap_mon_a: assert property (
    clk_en && req.valid && req.el == PLS_EL1 && req.sreg == PLS_SREG_KERNEL && trap_lower_q
    && !(ctx.nested_virt_enable && ctx.nested_virt_redirect)
    |=> resp_code == PLS_RESP_TRAP_EL3)
    else $error("kernel access not trapped to monitor");

  kernel_trap_hyp_a: assert property (
    clk_en && req.valid && req.el == PLS_EL1 && req.sreg == PLS_SREG_KERNEL && !trap_lower_q
    && el2_enabled && ctx.el2_aarch64 && trap_kernel_q && !ctx.nested_virt_enable
    |=> resp_code == PLS_RESP_TRAP_EL2)
    else $error("kernel access not trapped to hyp level");

  user_trap_hyp_a: assert property (
    clk_en && req.valid && req.el == PLS_EL1 && req.sreg == PLS_SREG_USER && !trap_lower_q
    && el2_enabled && ctx.el2_aarch64
    |=> resp_code == (trap_user_q ? PLS_RESP_TRAP_EL2 : PLS_RESP_OK))
    else $error("user register trap wrong");

  default_label_a: assert property (
    clk_en && !en_q |=> data_label.partition_id == PLS_DEF_PARTID
    && data_label.monitor_group == PLS_DEF_PMG && instr_label.partition_id == PLS_DEF_PARTID
    && instr_label.monitor_group == PLS_DEF_PMG)
    else $error("default label not used while disabled");

  mon_label_a: assert property (
    clk_en && en_q && cur_el == PLS_EL3 ##1 clk_en
    |-> data_label.partition_id == $past(mon_fields_q.data_partition_id)
    && instr_label.partition_id == $past(mon_fields_q.instr_partition_id))
    else $error("monitor label not taken from monitor register");

  hyp_en_ro_a: assert property (
    clk_en && HAS_EL3 && hyp_wr && !warm_apply && !mon_wr |=> en_q == $past(en_q))
    else $error("hyp write changed enable with monitor level present");

  mon_en_rw_a: assert property (
    clk_en && mon_wr && !warm_apply |=> en_q == $past(req.wdata[PLS_EN_BIT]))
    else $error("monitor write did not set enable");

  shared_en_a: assert property (
    clk_en && req.valid && !req.write && resp_now == PLS_RESP_OK
    && (req.sreg == PLS_SREG_HYP || req.sreg == PLS_SREG_MONITOR)
    |=> rdata[PLS_EN_BIT] == $past(en_q))
    else $error("enable bit differs between views");

  reserved_zero_a: assert property (
    resp_valid |-> (rdata[PLS_HYP_RSVD_HI:PLS_HYP_RSVD_LO] == '0
    || $past(req.sreg) == PLS_SREG_MONITOR)
    && (rdata[PLS_MON_RSVD_HI:PLS_MON_RSVD_LO] == '0 || $past(req.sreg) == PLS_SREG_HYP))
    else $error("reserved bits read nonzero");

  cold_reset_a: assert property (@(posedge core_clk)
    $rose(resetn) |-> trap_lower_q && !en_q)
    else $error("cold reset values wrong");

  trap_el2_c: cover property (resp_valid && resp_code == PLS_RESP_TRAP_EL2);
  trap_el3_c: cover property (resp_valid && resp_code == PLS_RESP_TRAP_EL3);
  hyp_label_c: cover property (en_q && cur_el == PLS_EL2 && el2_enabled);

endmodule : pls_label_regs

// *** dv/pls_core_model.sv ***
// core-side model: supplies the level 0 and 1 labels that the core computes
module pls_core_model
  import pls_pkg::*;
(
  input wire logic core_clk,
  input wire logic resetn,
  output pls_pkg::pls_label_s lower_data_label,
  output pls_pkg::pls_label_s lower_instr_label
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [15:0] step_q;

  // labels move every cycle so a stale pass-through shows up
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      step_q <= 16'h0000;
    end else begin
      step_q <= step_q + 16'h9e37;
    end
  end

  // level 0/1 labels as the core would hand them over
  assign lower_data_label = {step_q, step_q[7:0] ^ 8'ha5};
  assign lower_instr_label = {~step_q, step_q[15:8]};
endmodule : pls_core_model

// *** dv/partition_label_sysregs_tb.sv ***
// testbench: self-checking bench of the partition label register bank
module partition_label_sysregs_tb;
  import pls_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  localparam pls_ctx_s CTX_NS = pls_ctx_s'(5'b10100);
  logic core_clk, resetn, clk_en, warm_reset, reset_el_aarch64;
  pls_req_s req;
  pls_ctx_s ctx;
  logic [1:0] cur_el;
  pls_label_s lower_data_label, lower_instr_label, data_label, instr_label;
  logic resp_valid, label_enable;
  pls_resp_e resp_code;
  logic [63:0] rdata;
  int miscompares, n_compared;
  // reference state of the bank
  logic en_m, tl_m, t0_m, t1_m;
  logic [47:0] hf_m, mf_m, fw;

  pls_label_regs dut (.core_clk(core_clk), .resetn(resetn), .clk_en(clk_en),
    .warm_reset(warm_reset), .reset_el_aarch64(reset_el_aarch64), .req(req), .ctx(ctx),
    .cur_el(cur_el), .lower_data_label(lower_data_label),
    .lower_instr_label(lower_instr_label), .resp_valid(resp_valid), .resp_code(resp_code),
    .rdata(rdata), .label_enable(label_enable), .data_label(data_label),
    .instr_label(instr_label));
  pls_core_model core (.core_clk(core_clk), .resetn(resetn),
    .lower_data_label(lower_data_label), .lower_instr_label(lower_instr_label));

  // ***************************************************************
  // reference functions
  // ***************************************************************
  function automatic logic el2on(pls_ctx_s c);
    return (c.nonsecure_state | c.secure_hyp_enable) & c.el2_aarch64;
  endfunction : el2on

  function automatic pls_resp_e exp_code(pls_req_s r, pls_ctx_s c);
    logic nv, nv2;
    nv = c.nested_virt_enable;
    nv2 = c.nested_virt_redirect;
    if (r.el == PLS_EL0) return PLS_RESP_UNDEF;
    if (r.sreg == PLS_SREG_HYP && r.el < PLS_EL2) return PLS_RESP_UNDEF;
    if (r.sreg == PLS_SREG_MONITOR && r.el != PLS_EL3) return PLS_RESP_UNDEF;
    if (tl_m && (r.el == PLS_EL2 || (r.el == PLS_EL1 && !(nv && nv2))))
      return PLS_RESP_TRAP_EL3;
    if (r.el == PLS_EL1 && !tl_m && el2on(c)) begin
      if (r.sreg == PLS_SREG_KERNEL && ((t1_m && !nv) || (nv && !nv2)))
        return PLS_RESP_TRAP_EL2;
      if (r.sreg == PLS_SREG_USER && t0_m) return PLS_RESP_TRAP_EL2;
    end
    return PLS_RESP_OK;
  endfunction : exp_code

  function automatic logic [63:0] exp_rd(pls_req_s r, pls_resp_e ec);
    if (r.write || ec != PLS_RESP_OK) return '0;
    case (r.sreg)
      PLS_SREG_KERNEL: return {en_m, 63'h0};
      PLS_SREG_HYP: return {en_m, 13'h0, t0_m, t1_m, hf_m};
      PLS_SREG_MONITOR: return {en_m, tl_m, 14'h0, mf_m};
      default: return '0;
    endcase
  endfunction : exp_rd

  function automatic pls_label_s exp_lab(logic d, logic [1:0] el, pls_ctx_s c, pls_label_s lo);
    logic [47:0] f;
    f = (el == PLS_EL3) ? mf_m : hf_m;
    if (!en_m) return '0;
    if (el < PLS_EL2) return lo;
    if (el == PLS_EL2 && !el2on(c)) return '0;
    return d ? {f[31:16], f[47:40]} : {f[15:0], f[39:32]};
  endfunction : exp_lab

  // ***************************************************************
  // tasks
  // ***************************************************************
  task automatic cmp(input logic [63:0] got, input logic [63:0] exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp

  // one access, back to back with the next; valid left high for the caller
  task automatic access(input logic w, input pls_sreg_e s, input logic [1:0] el,
                        input logic [63:0] wd, input pls_ctx_s c, input logic [63:0] mask = '1);
    pls_req_s r;
    pls_resp_e ec;
    logic [63:0] er;
    r = '{valid: 1'b1, write: w, sreg: s, el: el, wdata: wd};
    ec = exp_code(r, c);
    er = exp_rd(r, ec);
    req = r;
    ctx = c;
    @(posedge core_clk);
    #1;
    cmp({63'h0, resp_valid}, 64'h1);
    cmp({62'h0, resp_code}, {62'h0, ec});
    cmp(rdata & mask, er & mask);
    if (ec == PLS_RESP_OK && w && s == PLS_SREG_MONITOR) begin
      en_m = wd[63];
      tl_m = wd[62];
      mf_m = wd[47:0];
    end else if (ec == PLS_RESP_OK && w && s == PLS_SREG_HYP) begin
      t0_m = wd[49];
      t1_m = wd[48];
      hf_m = wd[47:0];
    end
  endtask : access

  task automatic lab_chk(input logic [1:0] el, input pls_ctx_s c);
    pls_label_s pd, pi;
    req.valid = 1'b0;
    cur_el = el;
    ctx = c;
    @(posedge core_clk);
    #1;
    pd = lower_data_label;
    pi = lower_instr_label;
    @(posedge core_clk);
    #1;
    cmp({63'h0, label_enable}, {63'h0, en_m});
    cmp({40'h0, data_label}, {40'h0, exp_lab(1'b1, el, c, pd)});
    cmp({40'h0, instr_label}, {40'h0, exp_lab(1'b0, el, c, pi)});
  endtask : lab_chk

  task automatic results();
    if (miscompares == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : results

  // ***************************************************************
  // clock, watchdog and main sequence
  // ***************************************************************
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  initial begin
    #100000;
    miscompares++;
    results();
  end

  initial begin
    void'($urandom(78797));
    {resetn, warm_reset, en_m, t0_m, t1_m} = '0;
    {clk_en, reset_el_aarch64, tl_m} = 3'b111;
    req = '0;
    ctx = '0;
    cur_el = PLS_EL0;
    {hf_m, mf_m} = 'x;
    repeat (8) @(posedge core_clk);
    #1;
    resetn = 1'b1;
    t0_m = 1'b1;
    t1_m = 1'b1;
    cmp({63'h0, label_enable}, 64'h0);
    cmp({40'h0, data_label}, 64'h0);
    access(0, PLS_SREG_MONITOR, 3, 0, CTX_NS, 64'hffff_0000_0000_0000);
    access(0, PLS_SREG_HYP, 3, 0, CTX_NS, 64'hffff_0000_0000_0000);
    access(0, PLS_SREG_HYP, 2, 0, CTX_NS);
    access(0, PLS_SREG_KERNEL, 1, 0, CTX_NS);
    access(0, PLS_SREG_KERNEL, 1, 0, pls_ctx_s'(5'b10111));
    fw = 48'({$urandom, $urandom});
    access(1, PLS_SREG_MONITOR, 3, {16'hbfff, fw}, CTX_NS);
    access(0, PLS_SREG_MONITOR, 3, 0, CTX_NS);
    access(1, PLS_SREG_HYP, 3, {16'h7fff, ~fw}, CTX_NS);
    access(0, PLS_SREG_HYP, 2, 0, CTX_NS);
    access(0, PLS_SREG_KERNEL, 2, 0, CTX_NS);
    access(0, PLS_SREG_USER, 1, 0, CTX_NS);
    access(0, PLS_SREG_KERNEL, 1, 0, CTX_NS);
    access(1, PLS_SREG_HYP, 2, {16'h0000, fw}, CTX_NS);
    access(0, PLS_SREG_USER, 1, 0, CTX_NS);
    access(0, PLS_SREG_KERNEL, 1, 0, CTX_NS);
    access(0, PLS_SREG_KERNEL, 1, 0, pls_ctx_s'(5'b10110));
    access(0, PLS_SREG_KERNEL, 1, 0, pls_ctx_s'(5'b00110));
    access(0, PLS_SREG_MONITOR, 2, 0, CTX_NS);
    access(0, PLS_SREG_OTHER, 3, 0, CTX_NS);
    repeat (400) begin
      access(1'($urandom), pls_sreg_e'($urandom_range(3, 0)), 2'($urandom),
             {$urandom, $urandom}, pls_ctx_s'(5'($urandom)));
    end
    // labels for every level, enable off then on, hypervisor on and off
    for (int e = 0; e < 2; e++) begin
      access(1, PLS_SREG_MONITOR, 3, {e[0], 15'h0, fw}, CTX_NS);
      for (int l = 0; l < 4; l++) begin
        for (int h = 0; h < 2; h++) begin
          lab_chk(2'(l), pls_ctx_s'({h[0], 4'b0100}));
        end
      end
    end
    // warm reset only counts when resetting into a 64-bit level
    warm_reset = 1'b1;
    reset_el_aarch64 = 1'b0;
    @(posedge core_clk);
    #1;
    cmp({63'h0, label_enable}, {63'h0, en_m});
    reset_el_aarch64 = 1'b1;
    @(posedge core_clk);
    #1;
    warm_reset = 1'b0;
    en_m = 1'b0;
    cmp({63'h0, label_enable}, 64'h0);
    access(0, PLS_SREG_MONITOR, 3, 0, CTX_NS);
    // a frozen clock enable swallows a request
    clk_en = 1'b0;
    req = '{valid: 1'b1, write: 1'b1, sreg: PLS_SREG_MONITOR, el: PLS_EL3,
            wdata: 64'h8000_0000_0000_0000};
    repeat (2) @(posedge core_clk);
    #1;
    cmp({63'h0, resp_valid}, 64'h0);
    clk_en = 1'b1;
    req.valid = 1'b0;
    @(posedge core_clk);
    #1;
    cmp({63'h0, label_enable}, 64'h0);
    results();
  end
endmodule : partition_label_sysregs_tb
